// ===== design/sbi_dma_channels.sv
// Four independent DMA channels sharing one engine, Wishbone registers
//
// The address map and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
module sbi_dma_channels (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic [7:0]                    wbAdr,
  input  wire logic [31:0]                   wbDatI,
  output logic      [31:0]                   wbDatO,
  input  wire logic                          wbWe,
  input  wire logic [3:0]                    wbSel,
  input  wire logic                          wbCyc,
  input  wire logic                          wbStb,
  output logic                               wbAck,
  output logic                               irqOut,
  input  wire logic [sbi_pkg::NCH-1:0]       xferRequestIn,
  output logic      [sbi_pkg::NCH-1:0]       xferAckOut,
  input  wire logic [sbi_pkg::NCH-1:0]       xferDoneIn,
  output logic                               memStb,
  output logic                               memWe,
  output logic      [31:0]                   memAddr,
  output logic      [3:0]                    memSize,
  output logic      [63:0]                   memWdata,
  output logic                               memBurst,
  output logic                               memFly,
  input  wire logic [63:0]                   memRdata,
  input  wire logic                          memAck
);
  import sbi_pkg::*;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // legal unit sizes, burst moves full beats
  function automatic logic [LEN_W-1:0] szBytes(input logic [2:0] code);
    return (code >= SZ_BURST) ? LEN_W'(BEAT_B) : LEN_W'(1) << code[1:0];
  endfunction : szBytes

  function automatic logic [LEN_W-1:0] minOf(input logic [LEN_W-1:0] a, input logic [LEN_W-1:0] b);
    return (a < b) ? a : b;
  endfunction : minOf

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    return (old & ~m) | (d & m);
  endfunction : merge

  function automatic logic cfgOk(input logic [31:0] c);
    logic [LEN_W-1:0] ssm;
    logic [LEN_W-1:0] cap;
    ssm = LEN_W'(SSM_BASE) << c[F_SSM +: 2];
    cap = LEN_W'(BUF_UNIT) << c[F_WRP];
    if (c[F_STS +: 3] > SZ_BURST || c[F_DTS +: 3] > SZ_BURST)
      return 1'b0;
    // fly transfers skip the buffer checks
    if (c[F_SGL])
      return c[F_DIR +: 2] == DIR_M2P || c[F_DIR +: 2] == DIR_P2M;
    // staging area is a multiple of 32 bytes
    return ssm <= cap && c[F_DIR +: 2] != 2'h3;
  endfunction : cfgOk

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  sbi_state_t       state;
  sbi_state_t       next_state;
  logic [1:0]       cur;
  logic [1:0]       next_cur;
  logic [31:0]      ctrl     [NCH];
  logic [31:0]      srcAddr  [NCH];
  logic [31:0]      dstAddr  [NCH];
  logic [31:0]      bd       [NCH][2];
  logic [LEN_W-1:0] remain   [NCH];
  logic [LEN_W-1:0] fetchRem [NCH];
  logic [6:0]       bufCnt   [NCH];
  logic [5:0]       bufRd    [NCH];
  logic [7:0]       stage    [NCH][BUF_B];
  logic [NCH-1:0]   bdIdx;
  logic [NCH-1:0]   active;
  logic [NCH-1:0]   doneSeen;
  logic [NCH-1:0]   elig;
  logic [IRQ_W-1:0] irqStat;
  logic [IRQ_W-1:0] irqEn;
  logic [31:0]      rdData;
  logic [63:0]      drainData;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  wire        wbHit   = wbCyc && wbStb && !wbAck;
  wire        wbWr    = wbHit && wbWe;
  wire [2:0]  chSel   = wbAdr[7:5];
  wire        isCh    = chSel != 3'h0 && chSel <= 3'(NCH);
  wire [1:0]  chIdx   = 2'(chSel - 3'h1);
  wire [2:0]  regIdx  = wbAdr[4:2];
  wire [31:0] ctrlNew = merge(ctrl[chIdx], wbDatI, wbSel);
  wire        ctrlBad = !cfgOk(ctrlNew);
  wire        cfgWr   = wbWr && isCh && regIdx == R_CTRL;
  wire [31:0] enNew   = merge(32'(irqEn), wbDatI, wbSel);
  wire [31:0] clrWord = merge(32'h0000_0000, wbDatI, wbSel);
  wire        irqClr  = wbWr && !isCh && wbAdr == A_IRQ_CLR;

  // ------------------------------------------------------------------
  // Current channel quantities
  // ------------------------------------------------------------------
  // direction of the current channel
  wire [1:0]       dirC   = ctrl[cur][F_DIR +: 2];
  wire             sglC   = ctrl[cur][F_SGL];
  wire [LEN_W-1:0] stsB   = szBytes(ctrl[cur][F_STS +: 3]);
  wire [LEN_W-1:0] dtsB   = szBytes(ctrl[cur][F_DTS +: 3]);
  wire [LEN_W-1:0] ssmB   = LEN_W'(SSM_BASE) << ctrl[cur][F_SSM +: 2];
  wire [LEN_W-1:0] cnt    = LEN_W'(bufCnt[cur]);
  wire [LEN_W-1:0] fillW  = minOf(minOf(stsB, fetchRem[cur]), LEN_W'(BUF_B) - cnt);
  wire [LEN_W-1:0] drainW = minOf(dtsB, cnt);
  wire [LEN_W-1:0] flyW   = minOf(dtsB, remain[cur]);
  wire [3:0]       fillN  = 4'(fillW);
  wire [3:0]       drainN = 4'(drainW);
  wire [3:0]       flyN   = 4'(flyW);
  wire             accDone  = memStb && memAck;
  wire             closeNow = doneSeen[cur] || remain[cur] == '0;
  // keep filling until a steady-state unit is staged
  wire             fillMore = dirC != DIR_P2M && cnt + fillW < ssmB && fetchRem[cur] != fillW;
  wire             p2mFlush = cnt + fillW >= ssmB || fetchRem[cur] == fillW;
  wire             drainMore = dirC != DIR_M2P && cnt != drainW && remain[cur] != drainW;
  wire [1:0]       cand     = cur + 2'h1;

  // ------------------------------------------------------------------
  // Channel request and next state
  // ------------------------------------------------------------------
  // one virtual channel per generate slot
  for (genvar g = 0; g < NCH; g++)
  begin : g_elig
    // external pin or software request bit
    assign elig[g] = ctrl[g][F_EN] && ((bd[g][bdIdx[g]][B_RDY] &&
                     (ctrl[g][F_EXT] ? xferRequestIn[g] : ctrl[g][F_SWREQ])) || (active[g] && doneSeen[g]));
  end

  always_comb
  begin
    next_state = state;
    next_cur   = cur;
    case (state)
      ST_IDLE:
      begin
        next_cur = cand;
        if (elig[cand])
          next_state = active[cand] ? ST_PICK : ST_LOAD;
      end
      ST_LOAD:
        next_state = ST_PICK;
      ST_PICK:
        // length reached or done seen closes the descriptor
        if (closeNow)
          next_state = ST_CLOSE;
        else if (sglC)
          next_state = ST_FLY;
        else if (dirC == DIR_P2M)
          next_state = ST_FILL;
        // too few bytes left, read a fresh unit first
        else if (dirC == DIR_M2P)
          next_state = (cnt < dtsB && fetchRem[cur] != '0) ? ST_FILL : ST_DRAIN;
        // source read fills before destination write
        else
          next_state = (cnt == '0) ? ST_FILL : ST_DRAIN;
      ST_FILL:
        if (accDone)
          next_state = fillMore ? ST_FILL : (dirC != DIR_P2M || p2mFlush) ? ST_DRAIN : ST_ACKOFF;
      // toward a peripheral one unit is written per request
      ST_DRAIN:
        if (accDone)
          next_state = drainMore ? ST_DRAIN : (remain[cur] == drainW) ? ST_CLOSE : ST_ACKOFF;
      ST_FLY:
        if (accDone)
          next_state = (remain[cur] == flyW) ? ST_CLOSE : ST_ACKOFF;
      ST_CLOSE:
        next_state = ST_ACKOFF;
      ST_ACKOFF:
        next_state = ST_IDLE;
      default:
        next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= ST_IDLE;
      cur   <= 2'h0;
    end
    else
    begin
      state <= next_state;
      cur   <= next_cur;
    end
  end

  // ------------------------------------------------------------------
  // System bus access
  // ------------------------------------------------------------------
  wire        accState = state == ST_FILL || state == ST_DRAIN || state == ST_FLY;
  wire        startAcc = accState && !memStb;
  wire [31:0] flyAddr  = (dirC == DIR_M2P) ? srcAddr[cur] : dstAddr[cur];
  wire [31:0] accAddr  = (state == ST_FILL) ? srcAddr[cur] : (state == ST_DRAIN) ? dstAddr[cur] : flyAddr;
  wire        accWe    = state == ST_DRAIN || (state == ST_FLY && dirC == DIR_P2M);
  wire [3:0]  accSize  = (state == ST_FILL) ? fillN : (state == ST_DRAIN) ? drainN : flyN;
  // burst marker relies on memory set up for bursts
  wire        accBurst = (state == ST_FILL && ctrl[cur][F_STS +: 3] == SZ_BURST) ||
                         (state == ST_DRAIN && ctrl[cur][F_DTS +: 3] == SZ_BURST);
  wire        accPer   = state == ST_FLY || (state == ST_FILL && dirC == DIR_P2M) ||
                         (state == ST_DRAIN && dirC == DIR_M2P);

  for (genvar k = 0; k < BEAT_B; k++)
  begin : g_wdata
    assign drainData[8*k +: 8] = stage[cur][6'(bufRd[cur] + 6'(k))];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      memStb     <= 1'b0;
      memWe      <= 1'b0;
      memAddr    <= 32'h0000_0000;
      memSize    <= 4'h0;
      memWdata   <= 64'h0000_0000_0000_0000;
      memBurst   <= 1'b0;
      memFly     <= 1'b0;
      xferAckOut <= '0;
    end
    else if (startAcc)
    begin
      memStb   <= 1'b1;
      memWe    <= accWe;
      memAddr  <= accAddr;
      memSize  <= accSize;
      memWdata <= drainData;
      memBurst <= accBurst;
      // fly access carries no data from this block
      memFly   <= state == ST_FLY;
      // peripheral acknowledged while its access runs
      xferAckOut <= accPer ? NCH'(1) << cur : '0;
    end
    else if (accDone)
    begin
      memStb   <= 1'b0;
      memBurst <= 1'b0;
      memFly   <= 1'b0;
      // acknowledge released when the access ends
      xferAckOut <= '0;
    end
  end

  // ------------------------------------------------------------------
  // Per-channel registers and staging buffer
  // ------------------------------------------------------------------
  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    wire me   = cur == 2'(g);
    wire wrMe = wbWr && isCh && chIdx == 2'(g);

    always_ff @(posedge sys_clk)
    begin
      if (!rst_n)
      begin
        ctrl[g]     <= CTRL_RST;
        srcAddr[g]  <= 32'h0000_0000;
        dstAddr[g]  <= 32'h0000_0000;
        bd[g][0]    <= BD_RST;
        bd[g][1]    <= BD_RST;
        remain[g]   <= '0;
        fetchRem[g] <= '0;
        bufCnt[g]   <= 7'h00;
        bufRd[g]    <= 6'h00;
        bdIdx[g]    <= 1'b0;
        active[g]   <= 1'b0;
        doneSeen[g] <= 1'b0;
      end
      else
      begin
        if (wrMe)
          case (regIdx)
            R_CTRL:
              ctrl[g] <= ctrlBad ? (ctrlNew & ~(32'h0000_0001 << F_EN)) : ctrlNew;
            R_SRC:
              srcAddr[g] <= merge(srcAddr[g], wbDatI, wbSel);
            R_DST:
              dstAddr[g] <= merge(dstAddr[g], wbDatI, wbSel);
            R_BD0:
              bd[g][0] <= merge(bd[g][0], wbDatI, wbSel);
            R_BD1:
              bd[g][1] <= merge(bd[g][1], wbDatI, wbSel);
            default:
              ;
          endcase
        if (xferDoneIn[g] && active[g])
          doneSeen[g] <= 1'b1;
        if (me && state == ST_LOAD)
        begin
          remain[g]   <= LEN_W'(bd[g][bdIdx[g]]);
          fetchRem[g] <= LEN_W'(bd[g][bdIdx[g]]);
          active[g]   <= 1'b1;
        end
        if (me && accDone && state == ST_FILL)
        begin
          bufCnt[g]   <= 7'(cnt + fillW);
          fetchRem[g] <= fetchRem[g] - fillW;
          if (dirC != DIR_P2M)
            srcAddr[g] <= srcAddr[g] + 32'(fillW);
        end
        if (me && accDone && state == ST_DRAIN)
        begin
          bufCnt[g] <= 7'(cnt - drainW);
          bufRd[g]  <= 6'(bufRd[g] + 6'(drainN));
          remain[g] <= remain[g] - drainW;
          if (dirC != DIR_M2P)
            dstAddr[g] <= dstAddr[g] + 32'(drainW);
        end
        // fly moves count only, buffer untouched
        if (me && accDone && state == ST_FLY)
        begin
          remain[g]   <= remain[g] - flyW;
          fetchRem[g] <= fetchRem[g] - flyW;
          if (dirC == DIR_M2P)
            srcAddr[g] <= srcAddr[g] + 32'(flyW);
          else
            dstAddr[g] <= dstAddr[g] + 32'(flyW);
        end
        // hand back descriptor, step around the ring
        if (me && state == ST_CLOSE)
        begin
          bd[g][bdIdx[g]][B_RDY] <= 1'b0;
          bdIdx[g]    <= !(bd[g][bdIdx[g]][B_WRP] || bdIdx[g]);
          active[g]   <= 1'b0;
          doneSeen[g] <= 1'b0;
          bufCnt[g]   <= 7'h00;
          bufRd[g]    <= 6'h00;
        end
      end
    end

    always_ff @(posedge sys_clk)
    begin
      if (me && accDone && state == ST_FILL)
        for (int k = 0; k < BEAT_B; k++)
          if (k < int'(fillN))
            stage[g][6'(bufRd[g] + 6'(cnt) + 6'(k))] <= memRdata[8*k +: 8];
    end
  end

  // ------------------------------------------------------------------
  // Register read and interrupts
  // ------------------------------------------------------------------
  always_comb
  begin
    rdData = 32'h0000_0000;
    if (isCh)
      case (regIdx)
        R_CTRL:   rdData = ctrl[chIdx];
        R_SRC:    rdData = srcAddr[chIdx];
        R_DST:    rdData = dstAddr[chIdx];
        R_BD0:    rdData = bd[chIdx][0];
        R_BD1:    rdData = bd[chIdx][1];
        R_STAT:   rdData = 32'({doneSeen[chIdx], active[chIdx], bdIdx[chIdx], bufCnt[chIdx]});
        R_REMAIN: rdData = 32'(remain[chIdx]);
        default:  rdData = 32'h0000_0000;
      endcase
    else
      case (wbAdr)
        A_IRQ_STAT: rdData = 32'(irqStat);
        A_IRQ_EN:   rdData = 32'(irqEn);
        A_ENGINE:   rdData = {27'h000_0000, cur, 3'(state)};
        default:    rdData = 32'h0000_0000;
      endcase
  end

  wire [IRQ_W-1:0] evtClose = (state == ST_CLOSE) ? IRQ_W'(1) << cur : '0;
  wire [IRQ_W-1:0] evtCfg   = cfgWr && ctrlBad ? IRQ_W'(1) << (NCH + int'(chIdx)) : '0;
  wire [IRQ_W-1:0] clrMask  = irqClr ? clrWord[IRQ_W-1:0] : '0;

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wbAck   <= 1'b0;
      wbDatO  <= 32'h0000_0000;
      irqStat <= IRQ_RST;
      irqEn   <= IRQ_RST;
      irqOut  <= 1'b0;
    end
    else
    begin
      wbAck   <= wbHit;
      wbDatO  <= wbHit ? rdData : wbDatO;
      irqStat <= (irqStat & ~clrMask) | evtClose | evtCfg;
      irqEn   <= (wbWr && !isCh && wbAdr == A_IRQ_EN) ? enNew[IRQ_W-1:0] : irqEn;
      irqOut  <= |(irqStat & irqEn);
    end
  end

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  fly_ack_a: assert property (state == ST_FLY && memStb |-> xferAckOut[cur] && memFly)
    else $error("fly access without acknowledge");
  ack_drop_a: assert property (accDone |=> xferAckOut == '0 && !memStb)
    else $error("acknowledge held after access");
  fly_size_a: assert property (state == ST_FLY && memStb |-> memSize == flyN)
    else $error("fly unit is not the port size");
  fly_nobuf_a: assert property (state == ST_FLY && accDone |=> bufCnt[$past(cur)] == $past(bufCnt[cur]))
    else $error("fly access touched the buffer");
  short_fill_a: assert property (state == ST_PICK && !closeNow && !sglC && dirC == DIR_M2P &&
                                 cnt < dtsB && fetchRem[cur] != '0 |=> state == ST_FILL)
    else $error("short buffer did not refill");
  m2p_write_a: assert property (state == ST_FILL && accDone && dirC == DIR_M2P && !fillMore
                                |=> state == ST_DRAIN ##1 memStb && memWe && xferAckOut[cur])
    else $error("refill not followed by peripheral write");
  read_fill_a: assert property (memStb && !memWe && !memFly |-> state == ST_FILL)
    else $error("buffer read outside fill");
  close_irq_a: assert property (state == ST_PICK && closeNow |=> state == ST_CLOSE ##1 irqStat[$past(cur, 2)])
    else $error("descriptor close not reported");
  bad_cfg_a: assert property (cfgWr && ctrlBad |=> !ctrl[$past(chIdx)][F_EN])
    else $error("illegal configuration left enabled");
  fill_unit_a: assert property (state == ST_FILL && memStb |-> memSize <= 4'(BEAT_B) && memSize != 4'h0)
    else $error("fill unit out of range");
endmodule : sbi_dma_channels

// ===== design/sbi_pkg.sv
// Constants and types of the four-channel independent DMA block
package sbi_pkg;
  // ------------------------------------------------------------------
  // Sizes
  // ------------------------------------------------------------------
  localparam int NCH      = 4;
  localparam int LEN_W    = 24;
  localparam int IRQ_W    = 2 * NCH;
  localparam int BUF_B    = 64;
  localparam int BUF_UNIT = 32;
  localparam int SSM_BASE = 8;
  localparam int BEAT_B   = 8;

  // ------------------------------------------------------------------
  // Register map (byte offsets, channel register index)
  // ------------------------------------------------------------------
  localparam logic [7:0] A_IRQ_STAT = 8'h00;
  localparam logic [7:0] A_IRQ_EN   = 8'h04;
  localparam logic [7:0] A_IRQ_CLR  = 8'h08;
  localparam logic [7:0] A_ENGINE   = 8'h0C;
  localparam logic [2:0] R_CTRL     = 3'h0;
  localparam logic [2:0] R_SRC      = 3'h1;
  localparam logic [2:0] R_DST      = 3'h2;
  localparam logic [2:0] R_BD0      = 3'h3;
  localparam logic [2:0] R_BD1      = 3'h4;
  localparam logic [2:0] R_STAT     = 3'h5;
  localparam logic [2:0] R_REMAIN   = 3'h6;

  // ------------------------------------------------------------------
  // Fields and reset values
  // ------------------------------------------------------------------
  localparam int F_EN    = 0;
  localparam int F_DIR   = 1;
  localparam int F_SGL   = 3;
  localparam int F_EXT   = 4;
  localparam int F_SWREQ = 5;
  localparam int F_STS   = 6;
  localparam int F_DTS   = 9;
  localparam int F_SSM   = 12;
  localparam int F_WRP   = 14;
  localparam int B_RDY   = 31;
  localparam int B_WRP   = 30;
  localparam logic [1:0]  DIR_M2M  = 2'h0;
  localparam logic [1:0]  DIR_M2P  = 2'h1;
  localparam logic [1:0]  DIR_P2M  = 2'h2;
  localparam logic [2:0]  SZ_BURST = 3'h4;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] BD_RST   = 32'h0000_0000;
  localparam logic [7:0]  IRQ_RST  = 8'h00;

  typedef enum {ST_IDLE, ST_LOAD, ST_PICK, ST_FILL, ST_DRAIN, ST_FLY, ST_CLOSE, ST_ACKOFF} sbi_state_t;
endpackage : sbi_pkg

// ===== testbench/sbi_mem_model.sv
// System bus memory and fly-by peripheral data source
`timescale 1ns/1ps
module sbi_mem_model (
  input  wire logic        sys_clk,
  input  wire logic [1:0]  lat,
  input  wire logic        memStb,
  input  wire logic        memWe,
  input  wire logic [31:0] memAddr,
  input  wire logic [3:0]  memSize,
  input  wire logic [63:0] memWdata,
  input  wire logic        memBurst,
  input  wire logic        memFly,
  output logic      [63:0] memRdata = 64'h0000_0000_0000_0000,
  output logic             memAck = 1'b0,
  output int               nRd = 0
);
  logic [7:0] mem [0:1023];
  logic [1:0] waitCnt = 2'h0;
  initial for (int i = 0; i < 1024; i++) mem[i] = i[7:0] ^ 8'hA5;
  // Idle read lines toggle so stale data never looks valid
  always @(posedge sys_clk)
  begin
    memAck <= 1'b0;
    memRdata <= ~memRdata;
    if (!memStb || memAck)
      waitCnt <= 2'h0;
    else if (waitCnt != lat)
      waitCnt <= waitCnt + 2'h1;
    // bursts accepted, fly data from peripheral
    else
    begin
      memAck <= 1'b1;
      nRd <= nRd + int'(!memWe && !memBurst) + int'(!memWe && memBurst);
      for (int i = 0; i < 8; i++)
      begin
        memRdata[8*i+:8] <= mem[memAddr[9:0] + 10'(i)];
        if (memWe && i < memSize)
          mem[memAddr[9:0] + 10'(i)] <= memFly ? 8'h5A : memWdata[8*i+:8];
      end
    end
  end
endmodule : sbi_mem_model

// ===== testbench/test_sbi_dma_channels.sv
// Register, fly-by and staged transfer tests of the DMA channels
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin nErrors++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_sbi_dma_channels;
  import sbi_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0000_0000;
  logic [31:0] wbDatO;
  logic        wbWe = 1'b0;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbAck;
  logic        irqOut;
  logic [3:0]  xferRequestIn = 4'h0;
  logic [3:0]  xferDoneIn = 4'h0;
  logic [3:0]  xferAckOut;
  logic        memStb, memWe, memBurst, memFly, memAck;
  logic [31:0] memAddr;
  logic [3:0]  memSize;
  logic [63:0] memWdata, memRdata;
  logic [1:0]  lat = 2'h0;
  int          nRd;
  int          nErrors = 0;
  int          checked = 0;
  logic [31:0] q;
  int          spin;

  always #10 sys_clk = ~sys_clk;

  sbi_dma_channels u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .wbAdr(wbAdr), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbWe(wbWe), .wbSel(4'hF), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .irqOut(irqOut),
    .xferRequestIn(xferRequestIn), .xferAckOut(xferAckOut), .xferDoneIn(xferDoneIn), .memStb(memStb),
    .memWe(memWe), .memAddr(memAddr), .memSize(memSize), .memWdata(memWdata), .memBurst(memBurst),
    .memFly(memFly), .memRdata(memRdata), .memAck(memAck));
  sbi_mem_model u_mem (.sys_clk(sys_clk), .lat(lat), .memStb(memStb), .memWe(memWe), .memAddr(memAddr),
    .memSize(memSize), .memWdata(memWdata), .memBurst(memBurst), .memFly(memFly), .memRdata(memRdata),
    .memAck(memAck), .nRd(nRd));

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= d;
    @(posedge sys_clk);
    while (wbAck !== 1'b1 && n < 50)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 50) nErrors++;
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge sys_clk);
  endtask : wb

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0000_0000);
    `CHK(nm, e, q)
  endtask : rdc

  // One peripheral request, checked while its access stands
  task automatic serve(input int ch, input logic [31:0] a, input logic fly, input logic [7:0] wd,
                       input logic [3:0] sz);
    int n;
    n = 0;
    xferRequestIn[ch] <= 1'b1;
    while (xferAckOut[ch] !== 1'b1 && n < 200)
    begin
      @(posedge sys_clk);
      n++;
    end
    xferRequestIn[ch] <= 1'b0;
    `CHK("stb", 1'b1, memStb)
    `CHK("addr", a, memAddr)
    `CHK("we", 1'b1, memWe)
    `CHK("fly", fly, memFly)
    `CHK("size", sz, memSize)
    if (!fly) `CHK("wdata", wd, memWdata[7:0])
    while (xferAckOut[ch] !== 1'b0 && n < 400)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 200) nErrors++;
  endtask : serve

  task final_report;
    $display("errors %0d checks %0d", nErrors, checked);
    if (nErrors == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report

  initial
  begin
    #(20 * 20000);
    nErrors++;
    final_report;
  end

  initial
  begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    `CHK("irq", 1'b0, irqOut)
    rdc("ctrl", 8'h20, CTRL_RST);
    rdc("bd", 8'h2C, BD_RST);
    rdc("unmapped", 8'hF0, 32'h0000_0000);
    // Fly-by peripheral to memory, 4-byte unit per request
    wb(1'b1, 8'h28, 32'h0000_0100);
    wb(1'b1, 8'h2C, 32'hC000_0004);
    wb(1'b1, 8'h20, 32'h0000_049D);
    serve(0, 32'h0000_0100, 1'b1, 8'h00, 4'h4);
    repeat (4) @(posedge sys_clk);
    rdc("bd", 8'h2C, 32'h4000_0004);
    rdc("irqs", A_IRQ_STAT, 32'h0000_0001);
    `CHK("irq", 1'b0, irqOut)
    wb(1'b1, A_IRQ_EN, 32'h0000_0001);
    `CHK("irq", 1'b1, irqOut)
    wb(1'b1, A_IRQ_CLR, 32'h0000_0001);
    `CHK("irq", 1'b0, irqOut)
    rdc("irqs", A_IRQ_STAT, 32'h0000_0000);
    // Staged memory to peripheral: 4-byte reads, 1-byte writes
    lat <= 2'h2;
    wb(1'b1, 8'h44, 32'h0000_0200);
    wb(1'b1, 8'h48, 32'h0000_0300);
    wb(1'b1, 8'h4C, 32'hC000_0010);
    wb(1'b1, 8'h40, 32'h0000_0093);
    for (int i = 0; i < 16; i++)
    begin
      serve(1, 32'h0000_0300, 1'b0, 8'(i) ^ 8'hA5, 4'h1);
      `CHK("reads", (i < 8) ? 2 : 4, nRd)
    end
    repeat (4) @(posedge sys_clk);
    rdc("irqs", A_IRQ_STAT, 32'h0000_0002);
    // Illegal direction stores disabled and flags the channel
    wb(1'b1, 8'h60, 32'h0000_0007);
    rdc("ctrl", 8'h60, 32'h0000_0006);
    rdc("irqs", A_IRQ_STAT, 32'h0000_0042);
    // Done input closes a half-served fly-by descriptor
    wb(1'b1, 8'h2C, 32'hC000_0008);
    serve(0, 32'h0000_0104, 1'b1, 8'h00, 4'h4);
    xferDoneIn <= 4'h1;
    @(posedge sys_clk);
    xferDoneIn <= 4'h0;
    repeat (10) @(posedge sys_clk);
    rdc("bd", 8'h2C, 32'h4000_0008);
    rdc("remain", 8'h38, 32'h0000_0004);
    rdc("irqs", A_IRQ_STAT, 32'h0000_0043);
    `CHK("irq", 1'b1, irqOut)
    // Memory to memory on software request, burst read then 8-byte write
    wb(1'b1, 8'h88, 32'h0000_0380);
    wb(1'b1, 8'h8C, 32'hC000_0008);
    wb(1'b1, 8'h80, 32'h0000_0721);
    spin = 0;
    while (!(memStb === 1'b1 && memWe === 1'b0) && spin < 100)
    begin
      @(posedge sys_clk);
      spin++;
    end
    `CHK("burst", 1'b1, memBurst)
    `CHK("src", 32'h0000_0000, memAddr)
    `CHK("rsize", 4'h8, memSize)
    while (!(memStb === 1'b1 && memWe === 1'b1) && spin < 200)
    begin
      @(posedge sys_clk);
      spin++;
    end
    `CHK("burst", 1'b0, memBurst)
    `CHK("dst", 32'h0000_0380, memAddr)
    `CHK("wdata", 64'hA2A3_A0A1_A6A7_A4A5, memWdata)
    repeat (8) @(posedge sys_clk);
    rdc("remain", 8'h98, 32'h0000_0000);
    rdc("irqs", A_IRQ_STAT, 32'h0000_004B);
    final_report;
  end
endmodule : test_sbi_dma_channels
